// ===== src/fcd_fifo.sv
// Cascadable FIFO device: standard or fall-through timing, chosen at master reset.
// Assumes all inputs synchronous to ref_clk_i; neighbours join through the flag pins.
`timescale 1ns/1ns
`include "fcd_defines.svh"
module fcd_fifo (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic mode_fall_i,
    input wire logic write_en_n_i,
    input wire logic [`FCD_DW-1:0] write_data_bus_i,
    input wire logic read_en_n_i,
    output logic [`FCD_DW-1:0] read_data_bus_o,
    output logic empty_flag_n_o,
    output logic full_flag_n_o,
    output logic output_ready_n_o,
    output logic input_ready_n_o,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);
    // ------------------------------------------------------------
    // Mode strap and pointers
    // ------------------------------------------------------------
    fcd_pkg::fcd_mode_t mode, next_mode;
    logic [`FCD_PW-1:0] wr_ptr, wr_ptr_d1, wr_ptr_d2, rd_ptr, rd_ptr_d1, rd_ptr_d2;
    logic [`FCD_PW-1:0] next_wr_ptr, next_rd_ptr;
    logic ovalid, next_ovalid, full, next_full;
    logic [`FCD_DW-1:0] next_rdata, ram_q;
    logic next_empty_flag_n, next_output_ready_n;
    logic [31:0] ctrl, next_ctrl, next_reg_rdata;
    logic fall_mode, avail, wr_ok, take, load, pop;

    function automatic logic [`FCD_PW-1:0] fcd_level(input logic [`FCD_PW-1:0] w,
                                                     input logic [`FCD_PW-1:0] r);
        fcd_level = w - r;
    endfunction

    assign fall_mode = (mode == fcd_pkg::FCD_MODE_FALL);
    // Read side sees writes two cycles late, mimicking a pointer crossing
    // three-cycle fall
    assign avail = (wr_ptr_d2 != rd_ptr);
    assign wr_ok = !write_en_n_i && !full && !ctrl[`FCD_CTRL_HOLD_BIT];
    assign take = !read_en_n_i && (fall_mode ? ovalid : avail);
    assign load = fall_mode && avail && (!ovalid || take);
    assign pop = fall_mode ? load : take;

    always_comb begin
        next_mode = mode;
        if (sys_rst_i) begin
            next_mode = mode_fall_i ? fcd_pkg::FCD_MODE_FALL : fcd_pkg::FCD_MODE_STD;
        end
    end

    // ------------------------------------------------------------
    // Queue state
    // ------------------------------------------------------------
    always_comb begin
        next_wr_ptr = wr_ptr + `FCD_PW'(wr_ok);
        next_rd_ptr = rd_ptr + `FCD_PW'(pop);
        next_full = (fcd_level(next_wr_ptr, rd_ptr_d1) == `FCD_DEPTH);
        next_ovalid = ovalid;
        next_rdata = read_data_bus_o;
        if (fall_mode) begin
            if (load) begin
                next_ovalid = 1'b1;
                next_rdata = ram_q;
            end else if (take) begin
                next_ovalid = 1'b0;
            end
        end else if (take) begin
            next_rdata = ram_q;
        end
        next_empty_flag_n = fall_mode ? 1'b1 : (wr_ptr_d1 != next_rd_ptr);
        next_output_ready_n = fall_mode ? !next_ovalid : 1'b1;
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            wr_ptr <= '0;
            wr_ptr_d1 <= '0;
            wr_ptr_d2 <= '0;
            rd_ptr <= '0;
            rd_ptr_d1 <= '0;
            rd_ptr_d2 <= '0;
            full <= 1'b0;
            ovalid <= 1'b0;
            read_data_bus_o <= '0;
            empty_flag_n_o <= 1'b0;
            full_flag_n_o <= 1'b1;
            output_ready_n_o <= 1'b1;
            input_ready_n_o <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            wr_ptr_d1 <= wr_ptr;
            wr_ptr_d2 <= wr_ptr_d1;
            rd_ptr <= next_rd_ptr;
            rd_ptr_d1 <= rd_ptr;
            rd_ptr_d2 <= rd_ptr_d1;
            full <= next_full;
            ovalid <= next_ovalid;
            read_data_bus_o <= next_rdata;
            empty_flag_n_o <= next_empty_flag_n;
            full_flag_n_o <= fall_mode ? 1'b1 : !next_full;
            output_ready_n_o <= next_output_ready_n;
            input_ready_n_o <= fall_mode ? next_full : 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        mode <= next_mode;
    end

    // Address is the next read pointer so ram_q always shows the head word
    fcd_ram u_ram (
        .ref_clk_i(ref_clk_i),
        .wr_en_i(wr_ok),
        .wr_addr_i(wr_ptr[`FCD_AW-1:0]),
        .wr_data_i(write_data_bus_i),
        .rd_addr_i(next_rd_ptr[`FCD_AW-1:0]),
        .rd_data_o(ram_q)
    );

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_reg_rdata = 32'h00000000;
        if (reg_wr_i && reg_addr_i == `FCD_REG_CTRL) begin
            next_ctrl = {31'h00000000, reg_wdata_i[`FCD_CTRL_HOLD_BIT]};
        end
        if (reg_rd_i) begin
            if (reg_addr_i == `FCD_REG_CTRL) begin
                next_reg_rdata = ctrl;
            end else if (reg_addr_i == `FCD_REG_STATUS) begin
                next_reg_rdata[`FCD_ST_LEVEL_MSB:0] = fcd_level(wr_ptr, rd_ptr);
                next_reg_rdata[`FCD_ST_FALL_BIT] = fall_mode;
                next_reg_rdata[`FCD_ST_OVALID_BIT] = ovalid;
                next_reg_rdata[`FCD_ST_FULL_BIT] = full;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ctrl <= `FCD_CTRL_RST;
            reg_rdata_o <= 32'h00000000;
        end else begin
            ctrl <= next_ctrl;
            reg_rdata_o <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic quiet_empty;
    assign quiet_empty = (wr_ptr == rd_ptr) && (wr_ptr_d1 == wr_ptr) && (wr_ptr_d2 == wr_ptr)
                         && !ovalid;

    sequence s_fall_wait;
        output_ready_n_o [*3];
    endsequence

    sequence s_fall_done;
        !output_ready_n_o;
    endsequence

    property p_fall_latency;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        fall_mode && quiet_empty && wr_ok |=> s_fall_wait ##1 s_fall_done;
    endproperty
    a_fall_latency: assert property (p_fall_latency) else $error("fall-through not 3 cycles");

    property p_std_release;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !fall_mode && quiet_empty && wr_ok && read_en_n_i |-> ##3 empty_flag_n_o;
    endproperty
    a_std_release: assert property (p_std_release) else $error("empty flag late");

    property p_follow_on;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        fall_mode && ovalid && take && avail |=> !output_ready_n_o
            && read_data_bus_o == $past(ram_q);
    endproperty
    a_follow_on: assert property (p_follow_on) else $error("follow-on word delayed");

    property p_hold_word;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        fall_mode && !output_ready_n_o && read_en_n_i |=> !output_ready_n_o
            && $stable(read_data_bus_o);
    endproperty
    a_hold_word: assert property (p_hold_word) else $error("presented word lost");

    property p_ready_idle;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        fall_mode && wr_ptr == rd_ptr && !ovalid |=> output_ready_n_o;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready low while empty");

    property p_bubble;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        fall_mode && input_ready_n_o && take && write_en_n_i |-> ##3 !input_ready_n_o;
    endproperty
    a_bubble: assert property (p_bubble) else $error("free slot not shown in time");

    property p_full_blocks;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        // Full follows the delayed read pointer, so it must have settled
        full && !take && rd_ptr_d1 == rd_ptr_d2 |=> wr_ptr == $past(wr_ptr) && full;
    endproperty
    a_full_blocks: assert property (p_full_blocks) else $error("write into full queue");

    property p_level_step;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        wr_ok && !pop |=> fcd_level(wr_ptr, rd_ptr) == $past(fcd_level(wr_ptr, rd_ptr)) + 17'h00001;
    endproperty
    a_level_step: assert property (p_level_step) else $error("write not stored");
endmodule

// ===== src/fcd_defines.svh
// Constants of the cascadable single-clock FIFO: sizes, register map, timing.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef FCD_DEFINES_SVH
`define FCD_DEFINES_SVH

`define FCD_DW 36
`define FCD_AW 16
`define FCD_PW 17
`define FCD_DEPTH 17'h10000

`define FCD_REG_CTRL 8'h00
`define FCD_REG_STATUS 8'h04
`define FCD_CTRL_HOLD_BIT 0
`define FCD_CTRL_RST 32'h00000000
`define FCD_ST_LEVEL_MSB 16
`define FCD_ST_FALL_BIT 24
`define FCD_ST_OVALID_BIT 25
`define FCD_ST_FULL_BIT 26

`define FCD_FALL_CYC 3
`define FCD_BUBBLE_CYC 2

`endif

// ===== src/fcd_pkg.sv
// Types of the cascadable FIFO.
// Assumes the constants header is compiled alongside.
package fcd_pkg;
    typedef enum logic [1:0] {
        FCD_MODE_STD = 2'b01,
        FCD_MODE_FALL = 2'b10
    } fcd_mode_t;
endpackage

// ===== src/fcd_ram.sv
// Storage array of the FIFO with one write port and one registered read port.
// Assumes the caller keeps read and write addresses in range.
`timescale 1ns/1ns
`include "fcd_defines.svh"
module fcd_ram (
    input wire logic ref_clk_i,
    input wire logic wr_en_i,
    input wire logic [`FCD_AW-1:0] wr_addr_i,
    input wire logic [`FCD_DW-1:0] wr_data_i,
    input wire logic [`FCD_AW-1:0] rd_addr_i,
    output logic [`FCD_DW-1:0] rd_data_o
);
    logic [`FCD_DW-1:0] mem [0:(1<<`FCD_AW)-1];

    // No reset on the array; contents are don't-care until written
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

// ===== bench/fcd_sink.sv
// Downstream neighbour model: takes offered words on the shared clock unless held or randomly stalled.
// Assumes the bench seeds $urandom once and sets hold and stall rate.
`timescale 1ns/1ns
module fcd_sink (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic avail_i,
    input wire logic hold_i,
    input wire logic [6:0] stall_i,
    output logic read_en_n_o
);
    always @(posedge ref_clk_i) begin
        // A late view of avail may yield a refused read, which is harmless
        if (sys_rst_i || hold_i || !avail_i || ($urandom % 100) < stall_i) begin
            read_en_n_o <= 1'b1;
        end else begin
            read_en_n_o <= 1'b0;
        end
    end
endmodule

// ===== bench/testbench.sv
// Self-checking bench of the cascadable FIFO with a downstream reader model.
// Assumes the constants header is on the include path.
`timescale 1ns/1ns
`include "fcd_defines.svh"
module testbench;
    logic ref_clk_i, sys_rst_i, mode_fall_i, write_en_n_i, read_en_n, hold;
    logic reg_wr_i, reg_rd_i;
    logic [`FCD_DW-1:0] write_data_bus_i, read_data_bus_o;
    logic empty_flag_n_o, full_flag_n_o, output_ready_n_o, input_ready_n_o;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    logic [6:0] stall;
    logic [`FCD_DW-1:0] q[$];
    logic pend;
    int bad_count, compares;

    fcd_fifo i_fcd_fifo (.ref_clk_i, .sys_rst_i, .mode_fall_i, .write_en_n_i,
        .write_data_bus_i, .read_en_n_i(read_en_n), .read_data_bus_o, .empty_flag_n_o,
        .full_flag_n_o, .output_ready_n_o, .input_ready_n_o, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o);
    fcd_sink i_fcd_sink (.ref_clk_i, .sys_rst_i, .hold_i(hold), .stall_i(stall),
        .avail_i(mode_fall_i ? !output_ready_n_o : empty_flag_n_o), .read_en_n_o(read_en_n));

    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // --------------------------------------------------------
    // Result watcher: oldest note against each delivered word
    // --------------------------------------------------------
    initial begin
        pend = 1'b0;
        forever begin
            @(posedge ref_clk_i);
            #1;
            if (pend) chk(read_data_bus_o, q.size() ? q.pop_front() : 'x);
            pend = !sys_rst_i && !read_en_n && !mode_fall_i && empty_flag_n_o;
            if (!sys_rst_i && !read_en_n && mode_fall_i && !output_ready_n_o)
                chk(read_data_bus_o, q.size() ? q.pop_front() : 'x);
        end
    end

    initial begin
        repeat (90000) @(posedge ref_clk_i);
        bad_count++;
        final_report();
    end

    task automatic rst_dut(input logic m);
        @(posedge ref_clk_i);
        mode_fall_i <= m;
        sys_rst_i <= 1'b1;
        hold <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        q.delete();
        @(posedge ref_clk_i);
        #1;
    endtask

    task automatic wr(input logic [35:0] d);
        @(posedge ref_clk_i);
        write_en_n_i <= 1'b0;
        write_data_bus_i <= d;
        @(posedge ref_clk_i);
        write_en_n_i <= 1'b1;
    endtask

    task automatic reg_w(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_r(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e);
    endtask

    task automatic drain;
        int n;
        n = 0;
        hold <= 1'b0;
        while (q.size() != 0 && n < 3000) begin
            @(posedge ref_clk_i);
            n++;
        end
        chk(q.size(), 0);
    endtask

    initial begin
        logic [35:0] d;
        logic g;
        int i;
        sys_rst_i = 1'b1;
        mode_fall_i = 1'b1;
        write_en_n_i = 1'b1;
        write_data_bus_i = '0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        hold = 1'b1;
        stall = 7'h00;
        void'($urandom(35));
        rst_dut(1'b1);
        chk({output_ready_n_o, input_ready_n_o, empty_flag_n_o, full_flag_n_o}, 4'hB);
        reg_r(`FCD_REG_STATUS, 32'h01000000);
        reg_r(8'h08, 32'h0);
        d = {4'($urandom), 32'($urandom)};
        q.push_back(d);
        wr(d);
        repeat (2) @(posedge ref_clk_i);
        #1 chk(output_ready_n_o, 1'b1);
        @(posedge ref_clk_i);
        #1 chk(output_ready_n_o, 1'b0);
        chk(read_data_bus_o, d);
        // Held writes are dropped, so the array stays empty
        reg_w(`FCD_REG_CTRL, 32'h1);
        wr(~d);
        reg_r(`FCD_REG_CTRL, 32'h1);
        reg_r(`FCD_REG_STATUS, 32'h03000000);
        reg_w(`FCD_REG_CTRL, 32'h0);
        stall <= 7'h28;
        hold <= 1'b0;
        for (i = 0; i < 200; i++) begin
            @(posedge ref_clk_i);
            d = {4'($urandom), 32'($urandom)};
            g = ($urandom % 4) == 0;
            write_en_n_i <= g;
            write_data_bus_i <= d;
            if (!g) q.push_back(d);
        end
        @(posedge ref_clk_i);
        write_en_n_i <= 1'b1;
        drain();
        // one slice's full depth
        // Fill: array depth plus output register; the last write is refused
        hold <= 1'b1;
        stall <= 7'h00;
        for (i = 0; i < 65538; i++) begin
            @(posedge ref_clk_i);
            d = {4'($urandom), 32'($urandom)};
            write_en_n_i <= 1'b0;
            write_data_bus_i <= d;
            if (i < 65537) q.push_back(d);
        end
        @(posedge ref_clk_i);
        write_en_n_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1 chk(input_ready_n_o, 1'b1);
        reg_r(`FCD_REG_STATUS, 32'h07010000);
        @(posedge ref_clk_i);
        hold <= 1'b0;
        @(posedge ref_clk_i);
        hold <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1 chk(input_ready_n_o, 1'b1);
        @(posedge ref_clk_i);
        #1 chk(input_ready_n_o, 1'b0);
        rst_dut(1'b0);
        chk({output_ready_n_o, input_ready_n_o, empty_flag_n_o, full_flag_n_o}, 4'hD);
        reg_r(`FCD_REG_STATUS, 32'h0);
        d = {4'($urandom), 32'($urandom)};
        q.push_back(d);
        wr(d);
        #1 chk(empty_flag_n_o, 1'b0);
        @(posedge ref_clk_i);
        #1 chk(empty_flag_n_o, 1'b0);
        @(posedge ref_clk_i);
        #1 chk(empty_flag_n_o, 1'b1);
        drain();
        final_report();
    end
endmodule
